/* File: verif/ecid_contacts.sv */
`timescale 1ns/1ps
module ecid_contacts (
  input  wire        clk_i,
  output logic [8:0] pins_o
);
  initial pins_o = 9'h000;
  // contacts move on a clock edge; the wait covers sync plus debounce
  task automatic put(input int n, input logic v);
    @(posedge clk_i);
    pins_o[n] <= v;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

/* File: verif/ecid_decoder_assertions.sv */
`timescale 1ns/1ps
module ecid_decoder_assertions (
  input wire        CLK_I, RESET_N_I, CYC_I, STB_I, ACK_O, CARD_WRITE_I,
  input wire [31:0] DAT_O,
  input wire        SOURCE_POWER_O, FAULT_CLOSED_O, SCAN_ACTIVE_O,
  input wire        REMOTE_MODE_O, INPUT_ACCEPT_O, READY_TO_SCAN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  a_ack_follows: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acked");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside ack");
  a_ready_scan: assert property (READY_TO_SCAN_O == (SOURCE_POWER_O &&
    FAULT_CLOSED_O && !SCAN_ACTIVE_O && !CARD_WRITE_I)) else $error("ready to scan wrong");
  a_accept_remote: assert property (INPUT_ACCEPT_O |-> REMOTE_MODE_O)
    else $error("accept without remote");
  a_scan_start_ok: assert property ($rose(SCAN_ACTIVE_O) |-> SOURCE_POWER_O && FAULT_CLOSED_O)
    else $error("scan began while not possible");
  a_clear_remote: assert property ($rose(FAULT_CLOSED_O) |-> INPUT_ACCEPT_O)
    else $error("fault cleared outside remote");
  a_power_local: assert property (!INPUT_ACCEPT_O |=> $stable(SOURCE_POWER_O))
    else $error("power moved in local");
endmodule
bind ecid_decoder ecid_decoder_assertions u_chk (.*);

/* File: verif/ecid_decoder_test.sv */
`timescale 1ns/1ps
module ecid_decoder_test;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fev = 0, cw = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dw = 32'h0, dr, dat_o;
  logic [8:0]  pins;
  logic        ack, pwr, flt, scan, guide, urdy, rmt, acc, r2s, irq;
  logic [1:0]  unit;
  int          bad_count = 0, samples_checked = 0;
  initial forever #25 clk = ~clk;
  ecid_contacts u_pins (.clk_i(clk), .pins_o(pins));
  ecid_decoder #(.DEB_CYC(4)) dut (.CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dw), .DAT_O(dat_o),
    .ACK_O(ack), .POWER_CLOSED_I(pins[0]), .FAULT_CLEAR_CLOSED_I(pins[1]),
    .SCAN_START_CLOSED_I(pins[2]), .SCAN_STOP_CLOSED_I(pins[3]),
    .GUIDE_CLOSED_I(pins[4]), .REMOTE_CLOSED_I(pins[5]), .BEAM_SEL_CLOSED_I(pins[8:6]),
    .FAULT_EVENT_I(fev), .CARD_WRITE_I(cw), .SOURCE_POWER_O(pwr), .FAULT_CLOSED_O(flt),
    .SCAN_ACTIVE_O(scan), .GUIDE_BEAM_O(guide), .BEAM_UNIT_O(unit), .UNIT_READY_O(urdy),
    .REMOTE_MODE_O(rmt), .INPUT_ACCEPT_O(acc), .READY_TO_SCAN_O(r2s), .IRQ_O(irq));
  task report_and_stop;
    $display("mismatches %0d checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; ack waited for under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge clk);
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    if (ack !== 1'b1) begin
      bad_count++;
      report_and_stop;
    end else begin
      dr = dat_o;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    check("fault out", flt, 1);
    bus(0, 8'h14, 0);
    check("unmapped", dr, 0);
    u_pins.put(0, 1);
    check("power local", pwr, 0);
    u_pins.put(5, 1);
    check("accept", acc, 1);
    check("remote", rmt, 1);
    check("power on", pwr, 1);
    check("ready", r2s, 1);
    cw <= 1;
    @(posedge clk);
    check("ready card", r2s, 0);
    cw <= 0;
    u_pins.put(4, 1);
    check("guide on", guide, 1);
    u_pins.put(4, 0);
    check("guide off", guide, 0);
    for (int i = 0; i < 3; i++) begin
      u_pins.put(6 + i, 1);
      check("unit", unit, i + 1);
      check("unit ready", urdy, 1);
      u_pins.put(6 + i, 0);
    end
    u_pins.put(2, 1);
    check("scan", scan, 1);
    check("ready scan", r2s, 0);
    u_pins.put(3, 1);
    check("stop", scan, 0);
    u_pins.put(2, 0);
    u_pins.put(2, 1);
    check("both", scan, 0);
    u_pins.put(3, 0);
    u_pins.put(2, 0);
    bus(1, 8'h08, 32'h1f);
    bus(1, 8'h0c, 32'h01);
    fev <= 1;
    @(posedge clk);
    fev <= 0;
    repeat (3) @(posedge clk);
    check("fault set", flt, 0);
    check("irq", irq, 1);
    bus(1, 8'h0c, 0);
    check("irq masked", irq, 0);
    bus(1, 8'h0c, 1);
    bus(1, 8'h08, 1);
    check("irq cleared", irq, 0);
    check("fault held", flt, 0);
    u_pins.put(1, 1);
    check("fault clear", flt, 1);
    u_pins.put(5, 0);
    check("local", rmt, 0);
    check("no accept", acc, 0);
    u_pins.put(2, 1);
    check("start local", scan, 0);
    u_pins.put(0, 0);
    check("power hold", pwr, 1);
    bus(1, 8'h00, 1);
    bus(0, 8'h00, 0);
    check("ctrl", dr, 1);
    check("sw remote", rmt, 1);
    u_pins.put(2, 0);
    u_pins.put(2, 1);
    check("scan sw", scan, 1);
    u_pins.put(5, 1);
    check("power off", pwr, 0);
    bus(0, 8'h04, 0);
    check("state", dr, 32'h0000_00f4);
    bus(1, 8'h00, 32'h3);
    @(posedge clk);
    check("sw fault", flt, 0);
    check("fault stops scan", scan, 0);
    bus(0, 8'h08, 0);
    check("irq status", dr, 32'h3);
    check("irq fault", irq, 1);
    report_and_stop;
  end
endmodule

/* File: verilog/ecid_decoder.v */
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ecid_regs.vh"
module ecid_decoder #(
  parameter DEB_CYC = `ECID_DEB_CYC
) (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RESET_N_I,
  // wishbone slave
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [7:0]  ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output reg  [31:0] DAT_O,
  output wire        ACK_O,
  // contact inputs, high = closed
  input  wire        POWER_CLOSED_I,
  input  wire        FAULT_CLEAR_CLOSED_I,
  input  wire        SCAN_START_CLOSED_I,
  input  wire        SCAN_STOP_CLOSED_I,
  input  wire        GUIDE_CLOSED_I,
  input  wire        REMOTE_CLOSED_I,
  input  wire [2:0]  BEAM_SEL_CLOSED_I,
  // internal status
  input  wire        FAULT_EVENT_I,
  input  wire        CARD_WRITE_I,
  // actions and outputs, high = closed
  output reg         SOURCE_POWER_O,
  output wire        FAULT_CLOSED_O,
  output reg         SCAN_ACTIVE_O,
  output reg         GUIDE_BEAM_O,
  output reg  [1:0]  BEAM_UNIT_O,
  output reg         UNIT_READY_O,
  output wire        REMOTE_MODE_O,
  output wire        INPUT_ACCEPT_O,
  output wire        READY_TO_SCAN_O,
  output wire        IRQ_O
);
  // contact input slots
  localparam NIN       = 9;
  localparam IN_POWER  = 0;
  localparam IN_CLEAR  = 1;
  localparam IN_START  = 2;
  localparam IN_STOP   = 3;
  localparam IN_GUIDE  = 4;
  localparam IN_REMOTE = 5;
  localparam IN_BEAM1  = 6;
  localparam IN_BEAM2  = 7;
  localparam IN_BEAM3  = 8;
  // last count before a debounced change
  localparam [31:0] DEB_LIM = DEB_CYC - 1;

  reg  [1:0]            rst_sync_reg;
  wire                  rst_n;
  reg  [NIN-1:0]        sync1_reg;
  reg  [NIN-1:0]        sync2_reg;
  reg  [NIN-1:0]        deb_reg;
  reg  [NIN-1:0]        deb_prev_reg;
  reg  [15:0]           cnt_reg [0:NIN-1];
  reg                   fault_reg;
  reg                   ack_reg;
  reg  [31:0]           ctrl_reg;
  reg  [`ECID_EV_W-1:0] irq_stat_reg;
  reg  [`ECID_EV_W-1:0] irq_mask_reg;
  reg  [`ECID_EV_W-1:0] irq_stat_next;
  wire [NIN-1:0]        raw_in;
  wire [NIN-1:0]        rise;
  wire [NIN-1:0]        fall;
  wire                  remote;
  wire                  start_ok;
  wire                  wb_req;
  wire                  rd_stb;
  wire                  wr_stb;
  wire                  sw_fault;
  wire                  hit_ctrl;
  wire                  hit_state;
  wire                  hit_stat;
  wire                  hit_mask;
  wire                  hit_inputs;
  wire [31:0]           ctrl_merged;
  wire [31:0]           mask_merged;
  wire [31:0]           state_word;
  wire                  stop_wins;
  wire                  start_go;
  integer               k;

  // byte lane merge for writes
  function [31:0] ecid_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer b;
    begin
      ecid_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          ecid_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // address compare, used by every register
  function ecid_hit;
    input [7:0] adr;
    input [7:0] target;
    begin
      ecid_hit = (adr == target);
    end
  endfunction

  // inputs: 0 power,1 clear,2 start,3 stop,4 guide,5 remote,6..8 beam
  assign raw_in = {BEAM_SEL_CLOSED_I, REMOTE_CLOSED_I, GUIDE_CLOSED_I,
                   SCAN_STOP_CLOSED_I, SCAN_START_CLOSED_I,
                   FAULT_CLEAR_CLOSED_I, POWER_CLOSED_I};

  // reset release through two flops
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg    <= {NIN{1'b0}};
      sync2_reg    <= {NIN{1'b0}};
      deb_reg      <= {NIN{1'b0}};
      deb_prev_reg <= {NIN{1'b0}};
      for (k = 0; k < NIN; k = k + 1) begin
        cnt_reg[k] <= 16'h0000;
      end
    end else begin
      sync1_reg    <= raw_in;
      sync2_reg    <= sync1_reg;
      deb_prev_reg <= deb_reg;
      for (k = 0; k < NIN; k = k + 1) begin
        if (sync2_reg[k] == deb_reg[k]) begin
          cnt_reg[k] <= 16'h0000;
        end else if (cnt_reg[k] >= DEB_LIM[15:0]) begin
          cnt_reg[k] <= 16'h0000;
          deb_reg[k] <= sync2_reg[k];
        end else begin
          cnt_reg[k] <= cnt_reg[k] + 16'h0001;
        end
      end
    end
  end

  assign rise = deb_reg & ~deb_prev_reg;
  assign fall = ~deb_reg & deb_prev_reg;

  assign remote = deb_reg[IN_REMOTE];
  assign start_ok = remote | ctrl_reg[`ECID_CTRL_SW_REMOTE];
  assign INPUT_ACCEPT_O = remote;
  assign REMOTE_MODE_O  = start_ok;
  assign FAULT_CLOSED_O = ~fault_reg;
  assign READY_TO_SCAN_O = SOURCE_POWER_O & ~fault_reg & ~SCAN_ACTIVE_O & ~CARD_WRITE_I;

  // address decode
  assign hit_ctrl   = ecid_hit(ADR_I, `ECID_ADDR_CTRL);
  assign hit_state  = ecid_hit(ADR_I, `ECID_ADDR_STATE);
  assign hit_stat   = ecid_hit(ADR_I, `ECID_ADDR_IRQ_STAT);
  assign hit_mask   = ecid_hit(ADR_I, `ECID_ADDR_IRQ_MASK);
  assign hit_inputs = ecid_hit(ADR_I, `ECID_ADDR_INPUTS);

  // reads load on the request edge, writes land on the acked edge only
  assign wb_req      = CYC_I & STB_I & ~ack_reg;
  assign rd_stb      = wb_req & ~WE_I;
  assign wr_stb      = CYC_I & STB_I & WE_I & ack_reg;
  assign sw_fault    = wr_stb & hit_ctrl & SEL_I[0]
                       & DAT_I[`ECID_CTRL_FAULT_SET];
  assign ACK_O       = ack_reg;
  assign ctrl_merged = ecid_merge(ctrl_reg, DAT_I, SEL_I);
  assign mask_merged = ecid_merge({27'h0, irq_mask_reg}, DAT_I, SEL_I);

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SOURCE_POWER_O <= 1'b0;
    end else if (remote) begin
      SOURCE_POWER_O <= deb_reg[IN_POWER];
    end
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
    end else if (FAULT_EVENT_I | sw_fault) begin
      fault_reg <= 1'b1;
    end else if (remote & rise[IN_CLEAR]) begin
      fault_reg <= 1'b0;
    end
  end

  assign stop_wins = start_ok & (rise[IN_STOP] | (deb_reg[IN_STOP] & rise[IN_START]));
  assign start_go  = start_ok & rise[IN_START] & SOURCE_POWER_O & ~fault_reg;

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SCAN_ACTIVE_O <= 1'b0;
    end else if (stop_wins) begin
      SCAN_ACTIVE_O <= 1'b0;
    end else if (start_go) begin
      SCAN_ACTIVE_O <= 1'b1;
    // a standing fault ends any scan
    end else if (fault_reg) begin
      SCAN_ACTIVE_O <= 1'b0;
    end
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      GUIDE_BEAM_O <= 1'b0;
    end else if (remote & rise[IN_GUIDE]) begin
      GUIDE_BEAM_O <= 1'b1;
    end else if (remote & fall[IN_GUIDE]) begin
      GUIDE_BEAM_O <= 1'b0;
    end
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BEAM_UNIT_O  <= 2'h0;
      UNIT_READY_O <= 1'b0;
    end else if (remote) begin
      if (deb_reg[IN_BEAM1]) begin
        BEAM_UNIT_O  <= 2'h1;
        UNIT_READY_O <= 1'b1;
      end else if (deb_reg[IN_BEAM2]) begin
        BEAM_UNIT_O  <= 2'h2;
        UNIT_READY_O <= 1'b1;
      end else if (deb_reg[IN_BEAM3]) begin
        BEAM_UNIT_O  <= 2'h3;
        UNIT_READY_O <= 1'b1;
      end
    end
  end

  // irq: set wins over write-one clear
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stb & hit_stat & SEL_I[0]) begin
      irq_stat_next = irq_stat_next & ~DAT_I[`ECID_EV_W-1:0];
    end
    if (FAULT_EVENT_I | sw_fault) begin
      irq_stat_next[`ECID_EV_FAULT] = 1'b1;
    end
    if (start_ok & rise[IN_START]) begin
      irq_stat_next[`ECID_EV_START] = 1'b1;
    end
    if (start_ok & rise[IN_STOP]) begin
      irq_stat_next[`ECID_EV_STOP] = 1'b1;
    end
    if (remote & (rise[IN_GUIDE] | fall[IN_GUIDE])) begin
      irq_stat_next[`ECID_EV_GUIDE] = 1'b1;
    end
    if (remote & (|rise[IN_BEAM3:IN_BEAM1])) begin
      irq_stat_next[`ECID_EV_UNIT] = 1'b1;
    end
  end
  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  // wishbone ack, one cycle after the request
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // status bits take events every cycle
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= {`ECID_EV_W{1'b0}};
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // writable registers
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= `ECID_CTRL_RESET;
      irq_mask_reg <= {`ECID_EV_W{1'b0}};
    end else if (wr_stb) begin
      if (hit_ctrl) begin
        // fault-set bit is a strobe, never stored
        ctrl_reg <= ctrl_merged & 32'h0000_0001;
      end else if (hit_mask) begin
        irq_mask_reg <= mask_merged[`ECID_EV_W-1:0];
      end
    end
  end

  // state word as read back
  assign state_word = {23'h0, READY_TO_SCAN_O, INPUT_ACCEPT_O, BEAM_UNIT_O, start_ok,
                       GUIDE_BEAM_O, SCAN_ACTIVE_O, fault_reg, SOURCE_POWER_O};

  // read data stands only with ack
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      DAT_O <= 32'h0000_0000;
    end else begin
      DAT_O <= 32'h0000_0000;
      if (rd_stb) begin
        if (hit_ctrl) begin
          DAT_O <= ctrl_reg;
        end else if (hit_state) begin
          DAT_O <= state_word;
        end else if (hit_stat) begin
          DAT_O <= {27'h0, irq_stat_reg};
        end else if (hit_mask) begin
          DAT_O <= {27'h0, irq_mask_reg};
        end else if (hit_inputs) begin
          DAT_O <= {23'h0, deb_reg};
        end
      end
    end
  end
endmodule

/* File: verilog/ecid_regs.vh */
`ifndef ECID_REGS_VH
`define ECID_REGS_VH
// register byte addresses
`define ECID_ADDR_CTRL     8'h00
`define ECID_ADDR_STATE    8'h04
`define ECID_ADDR_IRQ_STAT 8'h08
`define ECID_ADDR_IRQ_MASK 8'h0c
`define ECID_ADDR_INPUTS   8'h10
// ctrl fields
`define ECID_CTRL_SW_REMOTE 0
`define ECID_CTRL_FAULT_SET 1
`define ECID_CTRL_RESET     32'h0000_0000
// state fields
`define ECID_ST_POWER    0
`define ECID_ST_FAULT    1
`define ECID_ST_SCAN     2
`define ECID_ST_GUIDE    3
`define ECID_ST_REMOTE   4
`define ECID_ST_UNIT_LSB 5
`define ECID_ST_RECEIVE  7
`define ECID_ST_READY    8
// irq event bits
`define ECID_EV_FAULT    0
`define ECID_EV_START    1
`define ECID_EV_STOP     2
`define ECID_EV_GUIDE    3
`define ECID_EV_UNIT     4
`define ECID_EV_W        5
// debounce time
`define ECID_CLK_HZ      20000000
`define ECID_DEB_US      1000
`define ECID_DEB_CYC     ((`ECID_DEB_US * (`ECID_CLK_HZ / 1000000)))
`endif
